/* core/foc_cfg.svh */
`ifndef FOC_CFG_SVH
`define FOC_CFG_SVH

// System clock period.
`define FOC_CLK_NS 40

// Round a time in ns up or down to whole clock cycles, never below one.
`define FOC_CYC_UP(ns) ((((ns) + `FOC_CLK_NS - 1) / `FOC_CLK_NS) < 1 ? 1 : (((ns) + `FOC_CLK_NS - 1) / `FOC_CLK_NS))
`define FOC_CYC_DN(ns) (((ns) / `FOC_CLK_NS) < 1 ? 1 : ((ns) / `FOC_CLK_NS))

// Latency figures in ns and fixed extra system clock periods.
`define FOC_PSUS_TYP_NS 7000
`define FOC_ESUS_TYP_NS 16000
`define FOC_ABORT_TYP_NS 16000
`define FOC_SUS_EXTRA 4
`define FOC_AISTOP_MAX_NS 80
`define FOC_AISTOP_EXTRA 15
`define FOC_MRSTOP_MIN_NS 10360
`define FOC_MRSTOP_EXTRA 4
`define FOC_RCV_MIN_NS 16000
`define FOC_RCV_EXTRA 7
`define FOC_MR16K_MIN_NS 73810
`define FOC_MR32K_MIN_NS 128430
`define FOC_MR64K_MIN_NS 237650
`define FOC_MR256K_MIN_NS 893010
`define FOC_MRFULL_MIN_NS 45210000

// Derived cycle counts.
`define FOC_PSUS_CYC (`FOC_CYC_UP(`FOC_PSUS_TYP_NS) + `FOC_SUS_EXTRA)
`define FOC_ESUS_CYC (`FOC_CYC_UP(`FOC_ESUS_TYP_NS) + `FOC_SUS_EXTRA)
`define FOC_ABORT_CYC (`FOC_CYC_UP(`FOC_ABORT_TYP_NS) + `FOC_SUS_EXTRA)
`define FOC_AISTOP_CYC (`FOC_CYC_DN(`FOC_AISTOP_MAX_NS) + `FOC_AISTOP_EXTRA)
`define FOC_MRSTOP_CYC (`FOC_CYC_UP(`FOC_MRSTOP_MIN_NS) + `FOC_MRSTOP_EXTRA)
`define FOC_RCV_CYC (`FOC_CYC_UP(`FOC_RCV_MIN_NS) + `FOC_RCV_EXTRA)
`define FOC_MR16K_CYC `FOC_CYC_UP(`FOC_MR16K_MIN_NS)
`define FOC_MR32K_CYC `FOC_CYC_UP(`FOC_MR32K_MIN_NS)

// Integrity check read counts per block size.
`define FOC_AI16K_READS 512
`define FOC_AI32K_READS 1024
`define FOC_AI64K_READS 2048
`define FOC_AI256K_READS 8192
`define FOC_AIFULL_READS 377000
`define FOC_AIPROP_READS 9960000

// Register byte offsets.
`define FOC_OFS_FMC 8'h00
`define FOC_OFS_UTC 8'h04
`define FOC_OFS_RCFG 8'h08
`define FOC_OFS_ICCNT 8'h0c

// flash_module_control fields.
`define FOC_FMC_HVE 0
`define FOC_FMC_PGM 1
`define FOC_FMC_ERS 2
`define FOC_FMC_PSUS 3
`define FOC_FMC_ESUS 4
`define FOC_FMC_LPM 5
`define FOC_FMC_DONE 8
`define FOC_FMC_READY 9

// user_test_control fields.
`define FOC_UTC_ICE 0
`define FOC_UTC_ICSUS 1
`define FOC_UTC_BRK 2
`define FOC_UTC_MARGIN 3
`define FOC_UTC_NONSEQ 4
`define FOC_UTC_SIZE_LO 5
`define FOC_UTC_SIZE_HI 7
`define FOC_UTC_ICDONE 8
`define FOC_UTC_ICBUSY 9

// Read configuration fields.
`define FOC_RCFG_RWSC_LO 0
`define FOC_RCFG_RWSC_HI 4
`define FOC_RCFG_APC_LO 8
`define FOC_RCFG_APC_HI 9

`endif

/* core/foc_flash_ctl.sv */
// Functional notes
// [RULE_01] A program suspend raises the operation-complete flag within 9.1 us plus four clock periods.
// [RULE_02] An erase suspend raises the operation-complete flag within 20.8 us plus four clock periods.
// [RULE_03] Clearing a suspend bit with high voltage enabled resumes and drops the flag within 100 ns.
// [RULE_04] A rising high-voltage enable starts the operation and clears the flag within 5 ns.
// [RULE_05] A falling high-voltage enable aborts and sets the flag within 20.8 us plus four periods.
// [RULE_06] After low-power exit the flash is ready after 16 to 45 us plus seven clock periods.
// [RULE_07] A rising check enable, or release of a check suspend or breakpoint, clears the check-done flag at once.
// [RULE_08] A falling check enable or a check suspend sets check-done within 80 ns plus fifteen periods.
// [RULE_09] A margin read abort or suspend sets check-done between 10.36 and 20.42 us plus four periods.
// [RULE_10] A sequential check reads 512, 1024, 2048 or 8192 times for a 16, 32, 64 or 256 KB block.
// [RULE_11] A sequential full-array check reads 3.77e5 times, the non-sequential order 9.96e6 times.
// [RULE_12] Each check read lasts the read wait cycles minus the pipeline depth, in clock periods.
// [RULE_13] Margin reads finish within 110.7 us, 1339.5 us and 60.26 ms for 16 KB, 256 KB and full array.
// [RULE_14] Software polls the completion flags before each new request and uses the bounds as timeouts.
`include "foc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module foc_flash_ctl import foc_pkg::*; #(
  parameter int CNT_W = 24,
  parameter int PE_CYC = 5000,
  parameter int MR64K_CYC = `FOC_CYC_UP(`FOC_MR64K_MIN_NS),
  parameter int MR256K_CYC = `FOC_CYC_UP(`FOC_MR256K_MIN_NS),
  parameter int MRFULL_CYC = `FOC_CYC_UP(`FOC_MRFULL_MIN_NS),
  parameter int AI256K_READS = `FOC_AI256K_READS,
  parameter int AIFULL_READS = `FOC_AIFULL_READS,
  parameter int AIPROP_READS = `FOC_AIPROP_READS
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Status.
  output logic flash_ready,
  output logic op_done,
  output logic check_done
);
  generate
    if (CNT_W < 24 || CNT_W > 31 || PE_CYC < 1 || MRFULL_CYC >= (1 << CNT_W) ||
        AIPROP_READS >= (1 << CNT_W) || MR64K_CYC < 1 || AI256K_READS < 1) begin : g_bad_param
      $error("foc_flash_ctl: parameter out of range");
    end
  endgenerate

  // Register state.
  logic hve_reg, hve_next;
  logic pgm_reg, pgm_next;
  logic ers_reg, ers_next;
  logic psus_reg, psus_next;
  logic esus_reg, esus_next;
  logic lpm_reg, lpm_next;
  logic ice_reg, ice_next;
  logic icsus_reg, icsus_next;
  logic brk_reg, brk_next;
  logic margin_reg, margin_next;
  logic nonseq_reg, nonseq_next;
  logic [2:0] size_reg, size_next;
  logic [4:0] rwsc_reg, rwsc_next;
  logic [1:0] apc_reg, apc_next;
  logic [31:0] rdata_reg, rdata_next;

  // Controller state.
  foc_pe_state_t pe_state_reg, pe_state_next;
  foc_ic_state_t ic_state_reg, ic_state_next;
  logic done_reg, done_next;
  logic icdone_reg, icdone_next;
  logic ready_reg, ready_next;

  // Write decode and edges of the control bits.
  logic wr_fmc, wr_utc, wr_rcfg;
  logic hve_rise, hve_fall, psus_rise, esus_rise, sus_clear;
  logic ice_rise, ice_fall, icsus_rise, icsus_fall, brk_rise, brk_fall;
  logic lpm_rise, lpm_fall;

  foc_tmr_if #(.W(CNT_W)) op_t();
  foc_tmr_if #(.W(CNT_W)) lat_t();
  foc_tmr_if #(.W(CNT_W)) stop_t();
  foc_tmr_if #(.W(CNT_W)) rcv_t();
  foc_pace_if #(.W(CNT_W)) pace();

  foc_timer #(.W(CNT_W)) u_op_tmr (.ref_clk(ref_clk), .rst_n(rst_n), .t(op_t.tmr));
  foc_timer #(.W(CNT_W)) u_lat_tmr (.ref_clk(ref_clk), .rst_n(rst_n), .t(lat_t.tmr));
  foc_timer #(.W(CNT_W)) u_stop_tmr (.ref_clk(ref_clk), .rst_n(rst_n), .t(stop_t.tmr));
  foc_timer #(.W(CNT_W)) u_rcv_tmr (.ref_clk(ref_clk), .rst_n(rst_n), .t(rcv_t.tmr));
  foc_pacer #(.W(CNT_W)) u_pacer (.ref_clk(ref_clk), .rst_n(rst_n), .p(pace.pacer));

  // Number of reads, or of clocks for a margin read, for the selected check.
  function automatic logic [CNT_W-1:0] check_limit(input logic [2:0] size, input logic margin,
                                                    input logic nonseq);
    logic [CNT_W-1:0] lim;
    lim = CNT_W'(`FOC_AI16K_READS);
    if (margin) begin
      case (size)
        SZ_16K: lim = CNT_W'(`FOC_MR16K_CYC);
        SZ_32K: lim = CNT_W'(`FOC_MR32K_CYC);
        SZ_64K: lim = CNT_W'(MR64K_CYC);
        SZ_256K: lim = CNT_W'(MR256K_CYC);
        default: lim = CNT_W'(MRFULL_CYC);
      endcase
    end else if (nonseq) begin
      lim = CNT_W'(AIPROP_READS);
    end else begin
      case (size)
        SZ_16K: lim = CNT_W'(`FOC_AI16K_READS);
        SZ_32K: lim = CNT_W'(`FOC_AI32K_READS);
        SZ_64K: lim = CNT_W'(`FOC_AI64K_READS);
        SZ_256K: lim = CNT_W'(AI256K_READS);
        default: lim = CNT_W'(AIFULL_READS);
      endcase
    end
    return lim;
  endfunction

  // Register writes and edge detection.
  always_comb begin
    wr_fmc = reg_wr && (reg_addr == `FOC_OFS_FMC);
    wr_utc = reg_wr && (reg_addr == `FOC_OFS_UTC);
    wr_rcfg = reg_wr && (reg_addr == `FOC_OFS_RCFG);
    hve_next = wr_fmc ? reg_wdata[`FOC_FMC_HVE] : hve_reg;
    pgm_next = wr_fmc ? reg_wdata[`FOC_FMC_PGM] : pgm_reg;
    ers_next = wr_fmc ? reg_wdata[`FOC_FMC_ERS] : ers_reg;
    psus_next = wr_fmc ? reg_wdata[`FOC_FMC_PSUS] : psus_reg;
    esus_next = wr_fmc ? reg_wdata[`FOC_FMC_ESUS] : esus_reg;
    lpm_next = wr_fmc ? reg_wdata[`FOC_FMC_LPM] : lpm_reg;
    ice_next = wr_utc ? reg_wdata[`FOC_UTC_ICE] : ice_reg;
    icsus_next = wr_utc ? reg_wdata[`FOC_UTC_ICSUS] : icsus_reg;
    brk_next = wr_utc ? reg_wdata[`FOC_UTC_BRK] : brk_reg;
    margin_next = wr_utc ? reg_wdata[`FOC_UTC_MARGIN] : margin_reg;
    nonseq_next = wr_utc ? reg_wdata[`FOC_UTC_NONSEQ] : nonseq_reg;
    size_next = wr_utc ? reg_wdata[`FOC_UTC_SIZE_HI:`FOC_UTC_SIZE_LO] : size_reg;
    rwsc_next = wr_rcfg ? reg_wdata[`FOC_RCFG_RWSC_HI:`FOC_RCFG_RWSC_LO] : rwsc_reg;
    apc_next = wr_rcfg ? reg_wdata[`FOC_RCFG_APC_HI:`FOC_RCFG_APC_LO] : apc_reg;
    hve_rise = hve_next && !hve_reg;
    hve_fall = !hve_next && hve_reg;
    psus_rise = psus_next && !psus_reg;
    esus_rise = esus_next && !esus_reg;
    sus_clear = (!psus_next && psus_reg) || (!esus_next && esus_reg);
    ice_rise = ice_next && !ice_reg;
    ice_fall = !ice_next && ice_reg;
    icsus_rise = icsus_next && !icsus_reg;
    icsus_fall = !icsus_next && icsus_reg;
    brk_rise = brk_next && !brk_reg;
    brk_fall = !brk_next && brk_reg;
    lpm_rise = lpm_next && !lpm_reg;
    lpm_fall = !lpm_next && lpm_reg;
  end

  // Low-power exit recovery; starts are refused until ready.
  always_comb begin
    ready_next = ready_reg;
    rcv_t.load = lpm_rise || lpm_fall;
    rcv_t.value = lpm_fall ? CNT_W'(`FOC_RCV_CYC) : '0; // RULE_06
    rcv_t.pause = 1'b0;
    if (lpm_rise) begin
      ready_next = 1'b0;
    end else if (rcv_t.expired) begin
      ready_next = 1'b1; // RULE_06
    end
  end

  // Program and erase sequencer.
  always_comb begin
    pe_state_next = pe_state_reg;
    done_next = done_reg;
    op_t.load = 1'b0;
    op_t.value = CNT_W'(PE_CYC);
    lat_t.load = 1'b0;
    lat_t.value = CNT_W'(`FOC_ABORT_CYC);
    case (pe_state_reg)
      PE_IDLE: begin
        if (hve_rise && ready_reg && (pgm_next || ers_next)) begin
          done_next = 1'b0; // RULE_04
          op_t.load = 1'b1;
          pe_state_next = PE_RUN;
        end
      end
      PE_RUN: begin
        if (hve_fall) begin
          lat_t.load = 1'b1; // RULE_05
          pe_state_next = PE_ABORT_WAIT;
        end else if (psus_rise && pgm_reg) begin
          lat_t.load = 1'b1;
          lat_t.value = CNT_W'(`FOC_PSUS_CYC); // RULE_01
          pe_state_next = PE_SUSP_WAIT;
        end else if (esus_rise && !pgm_reg) begin
          lat_t.load = 1'b1;
          lat_t.value = CNT_W'(`FOC_ESUS_CYC); // RULE_02
          pe_state_next = PE_SUSP_WAIT;
        end else if (op_t.expired) begin
          done_next = 1'b1;
          pe_state_next = PE_IDLE;
        end
      end
      PE_SUSP_WAIT: begin
        if (hve_fall) begin
          lat_t.load = 1'b1; // RULE_05
          pe_state_next = PE_ABORT_WAIT;
        end else if (lat_t.expired) begin
          done_next = 1'b1; // RULE_01 RULE_02
          pe_state_next = PE_SUSPENDED;
        end
      end
      PE_SUSPENDED: begin
        if (hve_fall) begin
          lat_t.load = 1'b1;
          pe_state_next = PE_ABORT_WAIT;
        end else if (sus_clear && hve_reg) begin
          done_next = 1'b0; // RULE_03
          pe_state_next = op_t.busy ? PE_RUN : PE_IDLE;
          done_next = !op_t.busy;
        end
      end
      PE_ABORT_WAIT: begin
        if (lat_t.expired) begin
          done_next = 1'b1; // RULE_05
          pe_state_next = PE_IDLE;
        end
      end
      default: begin
        pe_state_next = PE_IDLE;
        done_next = 1'b1;
      end
    endcase
    op_t.pause = !((pe_state_reg == PE_RUN) && !hve_fall && !(psus_rise && pgm_reg) && !(esus_rise && !pgm_reg));
    lat_t.pause = 1'b0;
  end

  // Margin read and array integrity sequencer.
  always_comb begin
    ic_state_next = ic_state_reg;
    icdone_next = icdone_reg;
    pace.start = 1'b0;
    pace.limit = check_limit(size_reg, margin_reg, nonseq_reg); // RULE_10 RULE_11 RULE_13
    pace.per_read = 6'h01;
    if (!margin_reg && ({1'b0, rwsc_reg} > {4'h0, apc_reg})) begin
      pace.per_read = {1'b0, rwsc_reg} - {4'h0, apc_reg}; // RULE_12
    end
    stop_t.load = 1'b0;
    stop_t.value = margin_reg ? CNT_W'(`FOC_MRSTOP_CYC) : CNT_W'(`FOC_AISTOP_CYC); // RULE_08 RULE_09
    case (ic_state_reg)
      IC_IDLE: begin
        if (ice_rise && ready_reg) begin
          icdone_next = 1'b0; // RULE_07
          pace.start = 1'b1;
          ic_state_next = IC_RUN;
        end
      end
      IC_RUN: begin
        if (ice_fall) begin
          stop_t.load = 1'b1; // RULE_08 RULE_09
          ic_state_next = IC_ABORT_WAIT;
        end else if (icsus_rise) begin
          stop_t.load = 1'b1; // RULE_08 RULE_09
          ic_state_next = IC_SUSP_WAIT;
        end else if (brk_rise) begin
          ic_state_next = IC_HALT;
        end else if (pace.finished) begin
          icdone_next = 1'b1;
          ic_state_next = IC_IDLE;
        end
      end
      IC_SUSP_WAIT: begin
        if (ice_fall) begin
          ic_state_next = IC_ABORT_WAIT;
        end else if (stop_t.expired) begin
          icdone_next = 1'b1;
          ic_state_next = IC_SUSPENDED;
        end
        if (ice_fall && stop_t.expired) begin
          icdone_next = 1'b1;
          ic_state_next = IC_IDLE;
        end
      end
      IC_SUSPENDED: begin
        if (ice_fall) begin
          ic_state_next = IC_IDLE;
        end else if (icsus_fall) begin
          icdone_next = 1'b0; // RULE_07
          ic_state_next = IC_RUN;
        end
      end
      IC_HALT: begin
        if (ice_fall) begin
          stop_t.load = 1'b1;
          ic_state_next = IC_ABORT_WAIT;
        end else if (brk_fall) begin
          icdone_next = 1'b0; // RULE_07
          ic_state_next = IC_RUN;
        end
      end
      IC_ABORT_WAIT: begin
        if (stop_t.expired) begin
          icdone_next = 1'b1;
          ic_state_next = IC_IDLE;
        end
      end
      default: begin
        ic_state_next = IC_IDLE;
        icdone_next = 1'b1;
      end
    endcase
    pace.run = (ic_state_reg == IC_RUN) && !ice_fall && !icsus_rise && !brk_rise;
    stop_t.pause = 1'b0;
  end

  // Read data, valid in the cycle after the strobe only.
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        `FOC_OFS_FMC: begin
          rdata_next[`FOC_FMC_HVE] = hve_reg;
          rdata_next[`FOC_FMC_PGM] = pgm_reg;
          rdata_next[`FOC_FMC_ERS] = ers_reg;
          rdata_next[`FOC_FMC_PSUS] = psus_reg;
          rdata_next[`FOC_FMC_ESUS] = esus_reg;
          rdata_next[`FOC_FMC_LPM] = lpm_reg;
          rdata_next[`FOC_FMC_DONE] = done_reg;
          rdata_next[`FOC_FMC_READY] = ready_reg;
        end
        `FOC_OFS_UTC: begin
          rdata_next[`FOC_UTC_ICE] = ice_reg;
          rdata_next[`FOC_UTC_ICSUS] = icsus_reg;
          rdata_next[`FOC_UTC_BRK] = brk_reg;
          rdata_next[`FOC_UTC_MARGIN] = margin_reg;
          rdata_next[`FOC_UTC_NONSEQ] = nonseq_reg;
          rdata_next[`FOC_UTC_SIZE_HI:`FOC_UTC_SIZE_LO] = size_reg;
          rdata_next[`FOC_UTC_ICDONE] = icdone_reg;
          rdata_next[`FOC_UTC_ICBUSY] = (ic_state_reg != IC_IDLE);
        end
        `FOC_OFS_RCFG: begin
          rdata_next[`FOC_RCFG_RWSC_HI:`FOC_RCFG_RWSC_LO] = rwsc_reg;
          rdata_next[`FOC_RCFG_APC_HI:`FOC_RCFG_APC_LO] = apc_reg;
        end
        `FOC_OFS_ICCNT: begin
          rdata_next[CNT_W-1:0] = pace.reads;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hve_reg <= 1'b0;
      pgm_reg <= 1'b0;
      ers_reg <= 1'b0;
      psus_reg <= 1'b0;
      esus_reg <= 1'b0;
      lpm_reg <= 1'b0;
      ice_reg <= 1'b0;
      icsus_reg <= 1'b0;
      brk_reg <= 1'b0;
      margin_reg <= 1'b0;
      nonseq_reg <= 1'b0;
      size_reg <= '0;
      rwsc_reg <= '0;
      apc_reg <= '0;
      rdata_reg <= '0;
      pe_state_reg <= PE_IDLE;
      ic_state_reg <= IC_IDLE;
      done_reg <= 1'b1;
      icdone_reg <= 1'b1;
      ready_reg <= 1'b1;
    end else begin
      hve_reg <= hve_next;
      pgm_reg <= pgm_next;
      ers_reg <= ers_next;
      psus_reg <= psus_next;
      esus_reg <= esus_next;
      lpm_reg <= lpm_next;
      ice_reg <= ice_next;
      icsus_reg <= icsus_next;
      brk_reg <= brk_next;
      margin_reg <= margin_next;
      nonseq_reg <= nonseq_next;
      size_reg <= size_next;
      rwsc_reg <= rwsc_next;
      apc_reg <= apc_next;
      rdata_reg <= rdata_next;
      pe_state_reg <= pe_state_next;
      ic_state_reg <= ic_state_next;
      done_reg <= done_next;
      icdone_reg <= icdone_next;
      ready_reg <= ready_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign flash_ready = ready_reg;
  assign op_done = done_reg;
  assign check_done = icdone_reg;
endmodule
`default_nettype wire

/* core/foc_ifs.sv */
`timescale 1ns/100ps
`default_nettype none
interface foc_tmr_if #(parameter int W = 24);
  logic load;
  logic [W-1:0] value;
  logic pause;
  logic busy;
  logic expired;
  modport tmr (input load, value, pause, output busy, expired);
  modport user (output load, value, pause, input busy, expired);
endinterface

interface foc_pace_if #(parameter int W = 24);
  logic start;
  logic run;
  logic [W-1:0] limit;
  logic [5:0] per_read;
  logic finished;
  logic [W-1:0] reads;
  modport pacer (input start, run, limit, per_read, output finished, reads);
  modport user (output start, run, limit, per_read, input finished, reads);
endinterface
`default_nettype wire

/* core/foc_pacer.sv */
`timescale 1ns/100ps
`default_nettype none
module foc_pacer #(parameter int W = 24) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control.
  foc_pace_if.pacer p
);
  logic active_reg, active_next;
  logic [W-1:0] rd_reg, rd_next;
  logic [5:0] cyc_reg, cyc_next;

  // Each read lasts per_read clocks; the run ends after limit reads.
  always_comb begin
    active_next = active_reg;
    rd_next = rd_reg;
    cyc_next = cyc_reg;
    p.finished = 1'b0;
    if (p.start) begin
      active_next = 1'b1;
      rd_next = '0;
      cyc_next = '0;
    end else if (active_reg && p.run) begin
      if (cyc_reg >= p.per_read - 6'h01) begin
        cyc_next = '0;
        rd_next = rd_reg + W'(1);
        if (rd_reg + W'(1) >= p.limit) begin
          active_next = 1'b0;
          p.finished = 1'b1;
        end
      end else begin
        cyc_next = cyc_reg + 6'h01;
      end
    end
    p.reads = rd_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
      rd_reg <= '0;
      cyc_reg <= '0;
    end else begin
      active_reg <= active_next;
      rd_reg <= rd_next;
      cyc_reg <= cyc_next;
    end
  end
endmodule
`default_nettype wire

/* core/foc_pkg.sv */
package foc_pkg;
  typedef enum logic [2:0] {PE_IDLE, PE_RUN, PE_SUSP_WAIT, PE_SUSPENDED, PE_ABORT_WAIT} foc_pe_state_t;
  typedef enum logic [2:0] {IC_IDLE, IC_RUN, IC_SUSP_WAIT, IC_SUSPENDED, IC_HALT, IC_ABORT_WAIT} foc_ic_state_t;
  typedef enum logic [2:0] {SZ_16K, SZ_32K, SZ_64K, SZ_256K, SZ_FULL} foc_size_t;
endpackage

/* core/foc_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module foc_timer #(parameter int W = 24) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control.
  foc_tmr_if.tmr t
);
  logic [W-1:0] cnt_reg, cnt_next;

  // A load restarts the count; a pause holds it; expiry pulses on the last step.
  always_comb begin
    cnt_next = cnt_reg;
    t.expired = 1'b0;
    if (t.load) begin
      cnt_next = t.value;
    end else if (cnt_reg != '0 && !t.pause) begin
      cnt_next = cnt_reg - W'(1);
      t.expired = (cnt_reg == W'(1));
    end
    t.busy = (cnt_reg != '0);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* verif/foc_flash_ctl_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module foc_flash_ctl_properties (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Status.
  input wire logic flash_ready,
  input wire logic op_done,
  input wire logic check_done
);
  // Shadow of the last written control bits, the margin bit written with the last rising check enable, and cycles since a low-power exit request.
  logic [5:0] fmc_reg;
  logic ice_reg;
  logic margin_reg;
  logic [11:0] rcv_reg;
  logic wf;
  logic wu;
  assign wf = reg_wr && reg_addr == 8'h00;
  assign wu = reg_wr && reg_addr == 8'h04;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fmc_reg <= 6'h00;
      ice_reg <= 1'b0;
      margin_reg <= 1'b0;
      rcv_reg <= 12'hfff;
    end else begin
      if (wf) fmc_reg <= reg_wdata[5:0];
      if (wu) ice_reg <= reg_wdata[0];
      if (wu && reg_wdata[0] && !ice_reg) margin_reg <= reg_wdata[3];
      if (wf && fmc_reg[5] && !reg_wdata[5]) rcv_reg <= 12'h000;
      else if (rcv_reg != 12'hfff) rcv_reg <= rcv_reg + 12'h001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_start_clear: assert property (wf && reg_wdata[0] && !fmc_reg[0] && |reg_wdata[2:1] && reg_wdata[4:3] == 2'h0
    && flash_ready && op_done |=> !op_done) else $error("op_done not cleared on start");
  chk_psus_latency: assert property (wf && reg_wdata[3] && !fmc_reg[3] && fmc_reg[0] && fmc_reg[1] && reg_wdata[0]
    && !op_done |-> ##[1:232] op_done) else $error("program suspend too slow");
  chk_esus_latency: assert property (wf && reg_wdata[4] && !fmc_reg[4] && fmc_reg[0] && fmc_reg[2] && !fmc_reg[1]
    && reg_wdata[0] && !op_done |-> ##[1:525] op_done) else $error("erase suspend too slow");
  chk_abort_latency: assert property (wf && fmc_reg[0] && !reg_wdata[0] && !op_done |-> ##[1:525] op_done)
    else $error("abort too slow");
  chk_lp_entry: assert property (wf && reg_wdata[5] |=> !flash_ready) else $error("ready kept in low power");
  chk_recover_window: assert property ($rose(flash_ready) |-> rcv_reg >= 12'h197 && rcv_reg <= 12'h46c)
    else $error("recovery outside window");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
  chk_ic_start: assert property (wu && reg_wdata[0] && !ice_reg && flash_ready && check_done |=> !check_done)
    else $error("check_done not cleared on start");
  chk_ic_abort: assert property (wu && ice_reg && !reg_wdata[0] && !check_done && !margin_reg
    |-> ##[1:18] check_done) else $error("integrity abort too slow");
  chk_mr_abort: assert property (wu && ice_reg && !reg_wdata[0] && !check_done && margin_reg
    |-> ##[1:515] check_done) else $error("margin abort too slow");
endmodule
bind foc_flash_ctl foc_flash_ctl_properties foc_flash_ctl_properties_i (.ref_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_ready, .op_done, .check_done);
`default_nettype wire

/* verif/foc_flash_ctl_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module foc_flash_ctl_test;
  logic ref_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic flash_ready;
  logic op_done;
  logic check_done;
  int fails = 0;
  int n_checks = 0;
  always #20 ref_clk = ~ref_clk;
  foc_flash_ctl #(.PE_CYC(1000), .MRFULL_CYC(50), .AI256K_READS(16),
    .AIFULL_READS(20), .AIPROP_READS(24)) foc_flash_ctl_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_ready(flash_ready), .op_done(op_done), .check_done(check_done));
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function logic flag(input int k);
    case (k)
      0: return op_done;
      1: return check_done;
      default: return flash_ready;
    endcase
  endfunction
  // Counts edges after the last write until the chosen flag is seen high.
  task wait_hi(input int k, output int n);
    n = 0;
    #1;
    while (flag(k) !== 1'b1 && n < 40000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  task t_reset;
    logic [31:0] d;
    wr(8'h10, 32'hffffffff);
    rd(8'h00, d);
    `CHK("fmc_reset", 32'h300, d)
    rd(8'h10, d);
    `CHK("unmapped", 32'h0, d)
    $display("test reset done");
  endtask
  task t_prog;
    int n;
    wr(8'h00, 32'h3);
    #1;
    `CHK("pgm_start", 1'b0, op_done)
    wr(8'h00, 32'hb);
    wait_hi(0, n);
    `CHK("psus_time", 1'b1, n <= 231)
    wr(8'h00, 32'h3);
    #1;
    `CHK("pgm_resume", 1'b0, op_done)
    wait_hi(0, n);
    `CHK("pgm_end", 1'b1, op_done)
    wr(8'h00, 32'h0);
    $display("test program done");
  endtask
  task t_erase;
    int n;
    wr(8'h00, 32'h5);
    #1;
    `CHK("ers_start", 1'b0, op_done)
    wr(8'h00, 32'h15);
    wait_hi(0, n);
    `CHK("esus_time", 1'b1, n <= 524)
    wr(8'h00, 32'h5);
    #1;
    `CHK("ers_resume", 1'b0, op_done)
    wr(8'h00, 32'h4);
    wait_hi(0, n);
    `CHK("abort_time", 1'b1, n <= 524 && op_done)
    $display("test erase done");
  endtask
  task t_lowpower;
    int n;
    wr(8'h00, 32'h20);
    #1;
    `CHK("lp_ready", 1'b0, flash_ready)
    wr(8'h00, 32'h0);
    wait_hi(2, n);
    `CHK("recover_time", 1'b1, n >= 407 && n <= 1132)
    $display("test low power done");
  endtask
  task t_check;
    int lim[6];
    int n;
    logic [31:0] r;
    lim = '{512, 1024, 2048, 16, 20, 24};
    wr(8'h08, 32'h205);
    for (int i = 0; i < 6; i++) begin
      wr(8'h04, i < 5 ? 32'(i * 32 + 1) : 32'h11);
      #1;
      `CHK("ic_start", 1'b0, check_done)
      wait_hi(1, n);
      `CHK("ic_time", 1'b1, n <= lim[i] * 3 && n >= lim[i] * 3 - 3)
      rd(8'h0c, r);
      `CHK("ic_reads", 32'(lim[i]), r)
      wr(8'h04, 32'h0);
    end
    $display("test integrity done");
  endtask
  task t_check_stop;
    int n;
    wr(8'h04, 32'h41);
    repeat (10) @(posedge ref_clk);
    wr(8'h04, 32'h43);
    wait_hi(1, n);
    `CHK("ic_susp_time", 1'b1, n <= 17)
    wr(8'h04, 32'h41);
    #1;
    `CHK("ic_resume", 1'b0, check_done)
    wr(8'h04, 32'h45);
    wr(8'h04, 32'h41);
    #1;
    `CHK("ic_brk_release", 1'b0, check_done)
    wr(8'h04, 32'h40);
    wait_hi(1, n);
    `CHK("ic_abort_time", 1'b1, n <= 17)
    wr(8'h04, 32'h09);
    wait_hi(1, n);
    `CHK("mr_time", 1'b1, n >= 1846 && n <= 2767)
    wr(8'h04, 32'h08);
    wr(8'h04, 32'h89);
    wait_hi(1, n);
    `CHK("mrfull_time", 1'b1, n == 50)
    wr(8'h04, 32'h08);
    wr(8'h04, 32'h09);
    repeat (20) @(posedge ref_clk);
    wr(8'h04, 32'h08);
    wait_hi(1, n);
    `CHK("mr_abort_time", 1'b1, n >= 263 && n <= 514)
    wr(8'h04, 32'h09);
    repeat (20) @(posedge ref_clk);
    wr(8'h04, 32'h0b);
    wait_hi(1, n);
    `CHK("mr_susp_time", 1'b1, n >= 263 && n <= 514)
    wr(8'h04, 32'h09);
    #1;
    `CHK("mr_resume", 1'b0, check_done)
    wait_hi(1, n);
    wr(8'h04, 32'h0);
    $display("test check stop done");
  endtask
  task conclude;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    $display("ERROR watchdog expired");
    conclude;
  end
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_prog;
    t_erase;
    t_lowpower;
    t_check;
    t_check_stop;
    conclude;
  end
endmodule
`default_nettype wire
